// >>> mvc_cfg.svh
// Purpose: Command codes, field positions, reset values for the manifold control link
// Assumes: Included by the package and the design modules
// Notes:   Codes and field layouts below are fixed by this block
`ifndef MVC_CFG_SVH
`define MVC_CFG_SVH

`define MVC_CMD_W           4
`define MVC_DATA_W          16
`define MVC_MODULES         4
`define MVC_VALVES          6
`define MVC_POSITIONS       5
`define MVC_ADC_LINES       13
`define MVC_ADC_BASE_HOT    0
`define MVC_ADC_BASE_COLD   8

`define MVC_CMD_VALVE_M1    4'h0
`define MVC_CMD_VALVE_M2    4'h1
`define MVC_CMD_VALVE_M3    4'h2
`define MVC_CMD_VALVE_M4    4'h3
`define MVC_CMD_REG_EN_WR   4'h4
`define MVC_CMD_REG_ST_RD   4'h5
`define MVC_CMD_MUX_SEL_WR  4'h6
`define MVC_CMD_MUX_SEL_RD  4'h7

`define MVC_VALVE_MASK_LSB  0
`define MVC_VALVE_ACT_BIT   6
`define MVC_SEL_W           15

`define MVC_REG_VALVE_BIT   0
`define MVC_REG_SENSOR_BIT  1
`define MVC_REG_MUXPWR_BIT  2
`define MVC_REG_MUXEN_BIT   3

`define MVC_SUPPLY_RST      3'h0
`define MVC_MUXEN_RST       1'h0
`define MVC_SEL_RST         15'h0000

`endif

// >>> mvc_pkg.sv
// Purpose: Shared types of the manifold control link
// Assumes: mvc_cfg.svh holds the numbers
// Notes:   Types only
`include "mvc_cfg.svh"

package mvc_pkg;
  typedef logic [`MVC_CMD_W-1:0]     mvc_cmd_t;
  typedef logic [`MVC_DATA_W-1:0]    mvc_word_t;
  typedef logic [`MVC_VALVES-1:0]    mvc_valve_t;
  typedef logic [`MVC_SEL_W-1:0]     mvc_sel_t;
  typedef logic [`MVC_MODULES-1:0]   mvc_mod_t;

  typedef enum logic [2:0] {
    MVC_H_IDLE   = 3'h1,
    MVC_H_STROBE = 3'h2,
    MVC_H_WAIT   = 3'h4
  } mvc_host_state_e;

  typedef struct packed {
    logic valve_wr;
    logic reg_en_wr;
    logic reg_st_rd;
    logic mux_sel_wr;
    logic mux_sel_rd;
    logic known;
  } mvc_dec_s;
endpackage : mvc_pkg

// >>> mvc_if.sv
// Purpose: Host I/O bus between slow_control_host and manifold_control_board
// Assumes: One clock, strobe then ack one cycle later
// Notes:   All signals one-way; no tri-state
`timescale 1ns/1ps

interface mvc_if;
  import mvc_pkg::*;
  logic      io_strobe;
  mvc_cmd_t  io_cmd;
  mvc_word_t io_wdata;
  logic      io_ack;
  mvc_word_t io_rdata;

  modport host (output io_strobe, output io_cmd, output io_wdata,
                input io_ack, input io_rdata);
  modport board (input io_strobe, input io_cmd, input io_wdata,
                 output io_ack, output io_rdata);
endinterface : mvc_if

// >>> mvc_cmd_decode.sv
// Purpose: Decodes a command code into command classes and a module index
// Assumes: Purely combinational
// Notes:   Unknown codes raise no class and clear known
`timescale 1ns/1ps
`include "mvc_cfg.svh"

module mvc_cmd_decode (
  input  wire mvc_pkg::mvc_cmd_t cmd,
  output mvc_pkg::mvc_dec_s      dec,
  output logic [1:0]             module_idx
);
  import mvc_pkg::*;

  always_comb begin
    dec        = '0;
    module_idx = cmd[1:0];
    unique case (cmd)
      `MVC_CMD_VALVE_M1, `MVC_CMD_VALVE_M2,
      `MVC_CMD_VALVE_M3, `MVC_CMD_VALVE_M4: begin
        dec.valve_wr = 1'b1;
      end
      `MVC_CMD_REG_EN_WR:  dec.reg_en_wr  = 1'b1;
      `MVC_CMD_REG_ST_RD:  dec.reg_st_rd  = 1'b1;
      `MVC_CMD_MUX_SEL_WR: dec.mux_sel_wr = 1'b1;
      `MVC_CMD_MUX_SEL_RD: dec.mux_sel_rd = 1'b1;
      default:             dec.known      = 1'b0;
    endcase
    if (dec.valve_wr || dec.reg_en_wr || dec.reg_st_rd || dec.mux_sel_wr || dec.mux_sel_rd) begin
      dec.known = 1'b1;
    end
  end
endmodule : mvc_cmd_decode

// >>> mvc_board.sv
// Purpose: manifold_control_board end: decodes host commands, drives valves,
//          sensor mux and regulator enables
// Assumes: Host strobes one command at a time and waits for ack
// Notes:   ADC_BASE selects hot_side_board (0) or cold_side_board (8)
`timescale 1ns/1ps
`include "mvc_cfg.svh"

module mvc_board #(
  parameter int ADC_BASE = `MVC_ADC_BASE_HOT
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  mvc_if.board                            bus,
  output logic [`MVC_MODULES*`MVC_VALVES-1:0] valve_drive,
  output mvc_pkg::mvc_mod_t               mux_module_sel,
  output logic [`MVC_ADC_LINES-1:0]       adc_line_enable,
  output logic                            valve_supply_en,
  output logic                            sensor_supply_en,
  output logic                            mux_supply_en,
  output logic                            mux_enable
);
  import mvc_pkg::*;

  // Module field 1..4 picks a module; anything else leaves the mux open
  function automatic mvc_mod_t sel_onehot(input mvc_sel_t sel);
    mvc_mod_t oh;
    oh = '0;
    if (sel >= `MVC_SEL_W'(1) && sel <= `MVC_SEL_W'(`MVC_MODULES)) begin
      oh[sel[1:0] - 2'd1] = 1'b1;
    end
    return oh;
  endfunction : sel_onehot

  mvc_dec_s   dec;
  logic [1:0] module_idx;

  mvc_valve_t valve_state      [`MVC_MODULES];
  mvc_valve_t next_valve_state [`MVC_MODULES];
  logic [2:0] supply_en;
  logic [2:0] next_supply_en;
  logic       mux_en;
  logic       next_mux_en;
  mvc_sel_t   mux_sel;
  mvc_sel_t   next_mux_sel;
  logic       ack;
  logic       next_ack;
  mvc_word_t  rdata;
  mvc_word_t  next_rdata;

  logic [`MVC_MODULES*`MVC_VALVES-1:0] next_valve_drive;
  mvc_mod_t                            next_mux_module_sel;
  logic [`MVC_ADC_LINES-1:0]           next_adc_line_enable;

  mvc_cmd_decode u_dec (
    .cmd        (bus.io_cmd),
    .dec        (dec),
    .module_idx (module_idx)
  );

  // Command state
  always_comb begin
    for (int m = 0; m < `MVC_MODULES; m++) begin
      next_valve_state[m] = valve_state[m];
    end
    next_supply_en = supply_en;
    next_mux_en    = mux_en;
    next_mux_sel   = mux_sel;
    next_ack       = 1'b0;
    next_rdata     = '0;
    if (bus.io_strobe) begin
      next_ack = 1'b1;
      if (dec.valve_wr) begin
        for (int v = 0; v < `MVC_VALVES; v++) begin
          if (bus.io_wdata[`MVC_VALVE_MASK_LSB + v]) begin
            next_valve_state[module_idx][v] = bus.io_wdata[`MVC_VALVE_ACT_BIT];
          end
        end
      end
      if (dec.reg_en_wr) begin
        next_supply_en[0] = bus.io_wdata[`MVC_REG_VALVE_BIT];
        next_supply_en[1] = bus.io_wdata[`MVC_REG_SENSOR_BIT];
        next_supply_en[2] = bus.io_wdata[`MVC_REG_MUXPWR_BIT];
        next_mux_en = bus.io_wdata[`MVC_REG_MUXEN_BIT];
      end
      if (dec.mux_sel_wr) begin
        next_mux_sel = bus.io_wdata[`MVC_SEL_W-1:0];
      end
      if (dec.reg_st_rd) begin
        next_rdata[`MVC_REG_VALVE_BIT]  = supply_en[0];
        next_rdata[`MVC_REG_SENSOR_BIT] = supply_en[1];
        next_rdata[`MVC_REG_MUXPWR_BIT] = supply_en[2];
        next_rdata[`MVC_REG_MUXEN_BIT]  = mux_en;
      end
      if (dec.mux_sel_rd) begin
        next_rdata[`MVC_SEL_W-1:0] = mux_sel;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int m = 0; m < `MVC_MODULES; m++) begin
        valve_state[m] <= '0;
      end
      supply_en <= `MVC_SUPPLY_RST;
      mux_en    <= `MVC_MUXEN_RST;
      mux_sel   <= `MVC_SEL_RST;
      ack       <= 1'b0;
      rdata     <= '0;
    end else begin
      for (int m = 0; m < `MVC_MODULES; m++) begin
        valve_state[m] <= next_valve_state[m];
      end
      supply_en <= next_supply_en;
      mux_en    <= next_mux_en;
      mux_sel   <= next_mux_sel;
      ack       <= next_ack;
      rdata     <= next_rdata;
    end
  end

  assign bus.io_ack   = ack;
  assign bus.io_rdata = rdata;

  // Pin drive values
  always_comb begin
    next_valve_drive     = '0;
    next_mux_module_sel  = '0;
    next_adc_line_enable = '0;
    // one switch per valve
    // Drives are gated by next_supply_en[0], one cycle ahead of valve_supply_en; held valve states drive the valves again once supply returns
    for (int m = 0; m < `MVC_MODULES; m++) begin
      for (int v = 0; v < `MVC_VALVES; v++) begin
        next_valve_drive[m*`MVC_VALVES + v] = valve_state[m][v] & next_supply_en[0];
      end
    end
    // four modules onto five lines
    // Mux needs both its supply and its enable before anything is routed
    if (mux_en && supply_en[2]) begin
      next_mux_module_sel = sel_onehot(mux_sel);
    end
    if (|next_mux_module_sel) begin
      for (int n = 0; n < `MVC_POSITIONS; n++) begin
        next_adc_line_enable[ADC_BASE + n] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valve_drive      <= '0;
      mux_module_sel   <= '0;
      adc_line_enable  <= '0;
      valve_supply_en  <= 1'b0;
      sensor_supply_en <= 1'b0;
      mux_supply_en    <= 1'b0;
      mux_enable       <= 1'b0;
    end else begin
      valve_drive      <= next_valve_drive;
      mux_module_sel   <= next_mux_module_sel;
      adc_line_enable  <= next_adc_line_enable;
      valve_supply_en  <= supply_en[0];
      sensor_supply_en <= supply_en[1];
      mux_supply_en    <= supply_en[2];
      mux_enable       <= mux_en;
    end
  end
endmodule : mvc_board

// >>> mvc_host.sv
// Purpose: slow_control_host end: issues one command per user request
// Assumes: Board acks one cycle after the strobe
// Notes:   Requests while busy are ignored
`timescale 1ns/1ps
`include "mvc_cfg.svh"

module mvc_host (
  input  wire logic               clk,
  input  wire logic               reset_n,
  mvc_if.host                     bus,
  input  wire logic               user_req,
  input  wire mvc_pkg::mvc_cmd_t  user_cmd,
  input  wire mvc_pkg::mvc_word_t user_wdata,
  output logic                    user_busy,
  output logic                    user_done,
  output mvc_pkg::mvc_word_t      user_rdata
);
  import mvc_pkg::*;

  mvc_host_state_e state;
  mvc_host_state_e next_state;
  logic            strobe;
  logic            next_strobe;
  mvc_cmd_t        cmd;
  mvc_cmd_t        next_cmd;
  mvc_word_t       wdata;
  mvc_word_t       next_wdata;
  logic            next_busy;
  logic            next_done;
  mvc_word_t       next_rdata;

  always_comb begin
    next_state  = state;
    next_strobe = 1'b0;
    next_cmd    = cmd;
    next_wdata  = wdata;
    next_busy   = user_busy;
    next_done   = 1'b0;
    next_rdata  = user_rdata;
    unique case (state)
      MVC_H_IDLE: begin
        if (user_req) begin
          next_state  = MVC_H_STROBE;
          next_strobe = 1'b1;
          next_cmd    = user_cmd;
          next_wdata  = user_wdata;
          next_busy   = 1'b1;
        end
      end
      MVC_H_STROBE: begin
        next_state = MVC_H_WAIT;
      end
      MVC_H_WAIT: begin
        if (bus.io_ack) begin
          next_state = MVC_H_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          next_rdata = bus.io_rdata;
        end
      end
      default: begin
        next_state = MVC_H_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= MVC_H_IDLE;
      strobe     <= 1'b0;
      cmd        <= '0;
      wdata      <= '0;
      user_busy  <= 1'b0;
      user_done  <= 1'b0;
      user_rdata <= '0;
    end else begin
      state      <= next_state;
      strobe     <= next_strobe;
      cmd        <= next_cmd;
      wdata      <= next_wdata;
      user_busy  <= next_busy;
      user_done  <= next_done;
      user_rdata <= next_rdata;
    end
  end

  assign bus.io_strobe = strobe;
  assign bus.io_cmd    = cmd;
  assign bus.io_wdata  = wdata;
endmodule : mvc_host

// >>> mvc_checker.sv
// Purpose: Bus checks between the hot-side host and board ends
// Assumes: Instantiated beside the hot-side mvc_if, one clock
// Notes:   Shadows keep the last regulator and select writes for the reads
`timescale 1ns/1ps
`include "mvc_cfg.svh"

module mvc_checker (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               io_strobe,
  input wire mvc_pkg::mvc_cmd_t  io_cmd,
  input wire mvc_pkg::mvc_word_t io_wdata,
  input wire logic               io_ack,
  input wire mvc_pkg::mvc_word_t io_rdata
);
  import mvc_pkg::*;
  logic [3:0] shadow;
  logic [3:0] next_shadow;
  logic [14:0] sel_shadow;
  logic [14:0] next_sel_shadow;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  always_comb begin
    next_shadow     = shadow;
    next_sel_shadow = sel_shadow;
    if (io_strobe && io_cmd == `MVC_CMD_REG_EN_WR)
      next_shadow = io_wdata[3:0];
    if (io_strobe && io_cmd == `MVC_CMD_MUX_SEL_WR)
      next_sel_shadow = io_wdata[14:0];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow     <= 4'h0;
      sel_shadow <= 15'h0000;
    end else begin
      shadow     <= next_shadow;
      sel_shadow <= next_sel_shadow;
    end
  end

  chk_ack_follows: assert property (io_strobe |=> io_ack)
    else $error("ack missing after strobe");
  chk_ack_cause: assert property (io_ack |-> $past(io_strobe))
    else $error("ack without strobe");
  chk_rdata_idle: assert property (!io_ack |-> io_rdata == 16'h0000)
    else $error("read data outside ack");
  chk_strobe_gap: assert property (io_strobe |=> !io_strobe [*2])
    else $error("strobes too close");
  chk_cmd_held: assert property (!io_strobe |-> $stable({io_cmd, io_wdata}))
    else $error("command changed without strobe");
  chk_unknown_zero: assert property (io_strobe && io_cmd[3] |=> io_rdata == 16'h0000)
    else $error("unknown code returned data");
  chk_status_shadow: assert property (io_strobe && io_cmd == `MVC_CMD_REG_ST_RD
    |=> io_rdata[3:0] == shadow)
    else $error("status read differs from last write");
  chk_sel_width: assert property (io_strobe && io_cmd == `MVC_CMD_MUX_SEL_RD
    |=> io_rdata == {1'b0, sel_shadow})
    else $error("select read differs from last write");
endmodule : mvc_checker

// >>> mvc_board_tb.sv
// Purpose: Drives hot and cold ends in parallel and judges board outputs
// Assumes: Both hosts see the same user requests
// Notes:   Cold end must match hot end except for its ADC lines
`timescale 1ns/1ps
`include "mvc_cfg.svh"

module mvc_board_tb;
  import mvc_pkg::*;
  logic        clk        = 1'b0;
  logic        reset_n    = 1'b0;
  logic        user_req   = 1'b0;
  mvc_cmd_t    user_cmd   = 4'h0;
  mvc_word_t   user_wdata = 16'h0000;
  wire [1:0]   busy;
  wire [1:0]   done;
  wire [15:0]  rd [2];
  wire [23:0]  drv [2];
  wire [3:0]   msel [2];
  wire [12:0]  adc [2];
  wire [3:0]   pwr [2];
  logic [23:0] vstate = 24'h0;
  logic [3:0]  epwr   = 4'h0;
  logic [14:0] raw    = 15'h0;
  int          num_errors  = 0;
  int          check_count = 0;

  always #4 clk = ~clk;

  mvc_if bus [2] ();
  for (genvar k = 0; k < 2; k++) begin : g_end
    mvc_host u_mvc_host (.clk(clk), .reset_n(reset_n), .bus(bus[k]), .user_req(user_req),
      .user_cmd(user_cmd), .user_wdata(user_wdata), .user_busy(busy[k]),
      .user_done(done[k]), .user_rdata(rd[k]));
    mvc_board #(.ADC_BASE(k * 8)) u_mvc_board (.clk(clk), .reset_n(reset_n),
      .bus(bus[k]), .valve_drive(drv[k]), .mux_module_sel(msel[k]),
      .adc_line_enable(adc[k]), .valve_supply_en(pwr[k][0]),
      .sensor_supply_en(pwr[k][1]), .mux_supply_en(pwr[k][2]), .mux_enable(pwr[k][3]));
  end

  mvc_checker u_mvc_checker (.clk(clk), .reset_n(reset_n), .io_strobe(bus[0].io_strobe),
    .io_cmd(bus[0].io_cmd), .io_wdata(bus[0].io_wdata), .io_ack(bus[0].io_ack),
    .io_rdata(bus[0].io_rdata));

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Both hosts run in lock step, so wait until both report done
  task automatic do_cmd(input mvc_cmd_t c, input mvc_word_t w);
    int n;
    @(negedge clk);
    user_req = 1'b1;
    user_cmd = c;
    user_wdata = w;
    @(negedge clk);
    user_req = 1'b0;
    check(busy, 32'h3);
    n = 0;
    while (done !== 2'b11 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      num_errors++;
      print_verdict();
    end
    check(busy, 32'h0);
  endtask : do_cmd

  task automatic rd_chk(input mvc_cmd_t c, input mvc_word_t exp);
    do_cmd(c, 16'h0000);
    check(rd[0], exp);
    check(rd[1], exp);
  endtask : rd_chk

  task automatic chk_all;
    logic [3:0]  s;
    logic [12:0] a;
    s = 4'h0;
    if (epwr[3] && epwr[2] && raw >= 15'd1 && raw <= 15'd4)
      s = 4'h1 << (raw[2:0] - 3'd1);
    a = (s != 4'h0) ? 13'h001f : 13'h0000;
    for (int k = 0; k < 2; k++) begin
      check(drv[k], vstate & {24{epwr[0]}});
      check(pwr[k], epwr);
      check(msel[k], s);
      check(adc[k], a << (k * 8));
    end
  endtask : chk_all

  task automatic wr_pwr(input logic [3:0] p);
    do_cmd(`MVC_CMD_REG_EN_WR, {12'h000, p});
    epwr = p;
  endtask : wr_pwr

  task automatic t_supply;
    for (int i = 0; i < 16; i++) begin
      wr_pwr(i[3:0]);
      chk_all();
      rd_chk(`MVC_CMD_REG_ST_RD, i[15:0]);
    end
    $display("test supply done");
  endtask : t_supply

  // Spare bits set high on purpose: they must not disturb the mask
  task automatic t_valves;
    wr_pwr(4'h1);
    for (int m = 0; m < 4; m++) begin
      do_cmd(m[3:0], 16'h01ed);
      vstate[m*6 +: 6] = vstate[m*6 +: 6] | 6'h2d;
      chk_all();
      do_cmd(m[3:0], 16'h0185);
      vstate[m*6 +: 6] = vstate[m*6 +: 6] & ~6'h05;
      chk_all();
    end
    wr_pwr(4'h0);
    chk_all();
    wr_pwr(4'h1);
    chk_all();
    $display("test valves done");
  endtask : t_valves

  task automatic t_mux;
    wr_pwr(4'hf);
    for (int s = 0; s < 6; s++) begin
      do_cmd(`MVC_CMD_MUX_SEL_WR, s[15:0]);
      raw = s[14:0];
      chk_all();
      rd_chk(`MVC_CMD_MUX_SEL_RD, s[15:0]);
    end
    do_cmd(`MVC_CMD_MUX_SEL_WR, 16'h7fff);
    raw = 15'h7fff;
    chk_all();
    rd_chk(`MVC_CMD_MUX_SEL_RD, 16'h7fff);
    do_cmd(`MVC_CMD_MUX_SEL_WR, 16'h0003);
    raw = 15'h3;
    wr_pwr(4'h7);
    chk_all();
    wr_pwr(4'hb);
    chk_all();
    rd_chk(`MVC_CMD_MUX_SEL_RD, 16'h0003);
    $display("test mux done");
  endtask : t_mux

  task automatic t_unknown;
    for (int c = 8; c < 16; c++) begin
      do_cmd(c[3:0], 16'hffff);
      check(rd[0], 32'h0);
      chk_all();
    end
    rd_chk(`MVC_CMD_REG_ST_RD, 16'h000b);
    $display("test unknown done");
  endtask : t_unknown

  // Also used mid-run, so held valves, supplies and select must all clear
  task automatic t_reset;
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    vstate = 24'h0;
    epwr   = 4'h0;
    raw    = 15'h0;
    chk_all();
    reset_n = 1'b1;
    rd_chk(`MVC_CMD_REG_ST_RD, 16'h0000);
    rd_chk(`MVC_CMD_MUX_SEL_RD, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  initial begin
    t_reset();
    t_supply();
    t_valves();
    t_mux();
    t_unknown();
    t_reset();
    print_verdict();
  end
endmodule : mvc_board_tb
